// ==== core/bitmr_pkg.sv ====
// Purpose: Constants shared by the basic interval timer files
// Assumes: 8-bit register port, byte addresses
// Notes: Status and mask registers sit beside the shared address
package bitmr_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_COUNT_CTRL = 8'hE6;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'hE7;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hE8;
  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int CSEL_LSB = 0;
  localparam int CSEL_W = 3;
  localparam int CLEAR_BIT = 3;
  localparam logic [2:0] CSEL_RESET = 3'h7;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  // ----------------------------------------------------------------
  // Status and mask fields
  // ----------------------------------------------------------------
  localparam int OVF_BIT = 0;
  localparam logic [7:0] MASK_RESET = 8'h00;
  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  localparam int PRE_W = 12;
  localparam int CSEL_BASE_SHIFT = 3;
  typedef enum logic {BITMR_RUN, BITMR_STOP} bitmr_pwr_t;
endpackage

// ==== core/bitmr_prescaler.sv ====
// Purpose: Free-running peripheral prescaler with power-of-two taps
// Assumes: Single clock, synchronous active-high reset
// Notes: Tap k pulses once every 2^k clocks; tap 0 is the undivided clock
`timescale 1ns/1ps
`default_nettype none
module bitmr_prescaler (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Gating
  input wire logic run,
  // Tap pulses, one cycle each
  output logic [bitmr_pkg::PRE_W:0] tap_pulse
);
  logic [bitmr_pkg::PRE_W-1:0] div_reg;
  logic [bitmr_pkg::PRE_W-1:0] div_next;
  assign div_next = div_reg + {{(bitmr_pkg::PRE_W-1){1'b0}}, 1'b1};
  // Tap k fires when the low k bits are all ones and the divider advances
  genvar k;
  generate
    for (k = 0; k <= bitmr_pkg::PRE_W; k++) begin : g_tap
      if (k == 0) begin : g_zero
        assign tap_pulse[k] = run;
      end else begin : g_div
        assign tap_pulse[k] = run & (&div_reg[k-1:0]);
      end
    end
  endgenerate
  always_ff @(posedge core_clk) begin
    if (reset) begin
      div_reg <= '0;
    end else if (run) begin
      div_reg <= div_next;
    end
  end
endmodule
`default_nettype wire

// ==== core/bitmr_top.sv ====
// Purpose: Basic interval timer with clock-select, clear and overflow irq
// Assumes: One 200 MHz clock; register port with read data a cycle later
// Notes: Count value and control share one address: read count, write control
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module bitmr_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Processor stop state
  input wire logic cpu_stop,
  // Interrupt
  output logic irq,
  // Peripheral tick out
  output logic count_tick
);
  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic [2:0] interval_clock_select_reg;
  logic interval_count_clear_reg;
  logic [7:0] interval_count_value_reg;
  logic [7:0] irq_status_reg;
  logic [7:0] irq_mask_reg;
  logic [7:0] count_next;
  logic [7:0] status_next;
  logic [7:0] rdata_next;
  logic irq_next;
  bitmr_pkg::bitmr_pwr_t pwr_reg;
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;
  logic sel_ctrl;
  logic sel_status;
  logic sel_mask;
  logic clear_req;
  logic step;
  logic wrap;
  logic [bitmr_pkg::PRE_W:0] tap_pulse;
  logic [3:0] tap_index;
  assign sel_ctrl = (reg_addr == bitmr_pkg::ADDR_COUNT_CTRL);
  assign sel_status = (reg_addr == bitmr_pkg::ADDR_IRQ_STATUS);
  assign sel_mask = (reg_addr == bitmr_pkg::ADDR_IRQ_MASK);
  assign wr_ctrl = reg_wr & sel_ctrl;
  assign wr_status = reg_wr & sel_status;
  assign wr_mask = reg_wr & sel_mask;
  assign clear_req = wr_ctrl & reg_wdata[bitmr_pkg::CLEAR_BIT];
  // Unmapped reads return zero
  assign rdata_next = !reg_rd ? 8'h00 :
                      sel_ctrl ? interval_count_value_reg :
                      sel_status ? irq_status_reg :
                      sel_mask ? irq_mask_reg : 8'h00;
  // ----------------------------------------------------------------
  // Prescaler and count step
  // ----------------------------------------------------------------
  bitmr_prescaler u_pre (
    .core_clk(core_clk),
    .reset(reset),
    .run(pwr_reg == bitmr_pkg::BITMR_RUN),
    .tap_pulse(tap_pulse)
  );
  assign tap_index = 4'(interval_clock_select_reg) + 4'(bitmr_pkg::CSEL_BASE_SHIFT);
  assign step = tap_pulse[tap_index];
  assign wrap = step & (interval_count_value_reg == bitmr_pkg::COUNT_MAX);
  // Clear wins over a step in the same cycle
  assign count_next = (clear_req | interval_count_clear_reg) ? bitmr_pkg::COUNT_RESET :
                      step ? interval_count_value_reg + 8'h01 :
                      interval_count_value_reg;
  // Set wins over a write-one-to-clear in the same cycle
  assign status_next = (irq_status_reg & ~(wr_status ? reg_wdata : 8'h00)) |
                       (wrap ? 8'h01 : 8'h00);
  assign irq_next = |(status_next & irq_mask_reg);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      interval_clock_select_reg <= bitmr_pkg::CSEL_RESET;
      interval_count_clear_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        interval_clock_select_reg <= reg_wdata[bitmr_pkg::CSEL_W-1:0];
      end
      interval_count_clear_reg <= clear_req;
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      interval_count_value_reg <= bitmr_pkg::COUNT_RESET;
    end else begin
      interval_count_value_reg <= count_next;
    end
  end
  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_status_reg <= 8'h00;
    end else begin
      irq_status_reg <= status_next;
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_mask_reg <= bitmr_pkg::MASK_RESET;
    end else begin
      if (wr_mask) begin
        irq_mask_reg <= reg_wdata;
      end
    end
  end
  // Built from next status so irq never lags the flag
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_next;
    end
  end
  // ----------------------------------------------------------------
  // Bus and tick outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
      count_tick <= 1'b0;
    end else begin
      reg_rdata <= rdata_next;
      count_tick <= step;
    end
  end
  // ----------------------------------------------------------------
  // Stop state tracking
  // ----------------------------------------------------------------
  // One cycle of latency: the prescaler still runs on the entry cycle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pwr_reg <= bitmr_pkg::BITMR_RUN;
    end else begin
      case (pwr_reg)
        bitmr_pkg::BITMR_RUN: begin
          if (cpu_stop) begin
            pwr_reg <= bitmr_pkg::BITMR_STOP;
          end
        end
        bitmr_pkg::BITMR_STOP: begin
          if (!cpu_stop) begin
            pwr_reg <= bitmr_pkg::BITMR_RUN;
          end
        end
        default: begin
          pwr_reg <= bitmr_pkg::BITMR_RUN;
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Step spacing monitor for assertions
  // ----------------------------------------------------------------
  // Spacing is only trusted between two steps with no select write or stop
  logic [10:0] step_gap_reg;
  logic [10:0] step_gap_next;
  logic gap_valid_reg;
  logic gap_valid_next;
  logic gap_hold;
  assign gap_hold = wr_ctrl | cpu_stop | (pwr_reg == bitmr_pkg::BITMR_STOP);
  assign step_gap_next = step ? 11'h001 :
                         (step_gap_reg == 11'h7FF) ? step_gap_reg : step_gap_reg + 11'h001;
  assign gap_valid_next = gap_hold ? 1'b0 : (step | gap_valid_reg);
  always_ff @(posedge core_clk) begin
    if (reset) begin
      step_gap_reg <= 11'h000;
      gap_valid_reg <= 1'b0;
    end else begin
      step_gap_reg <= step_gap_next;
      gap_valid_reg <= gap_valid_next;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_reset_slow_select: assert property (@(posedge core_clk)
    (!reset && $past(reset)) |-> interval_clock_select_reg == 3'h7)
    else $error("clock select not all ones after reset");
  a_clear_self_drop: assert property (@(posedge core_clk) disable iff (reset)
    interval_count_clear_reg |=> !interval_count_clear_reg || $past(clear_req))
    else $error("clear bit did not drop");
  a_clear_zero_count: assert property (@(posedge core_clk) disable iff (reset)
    clear_req |=> interval_count_value_reg == 8'h00 ##1 interval_count_value_reg == 8'h00)
    else $error("count not zero after clear");
  a_wrap_sets_flag: assert property (@(posedge core_clk) disable iff (reset)
    (wrap && !interval_count_clear_reg && !clear_req) |=> irq_status_reg[0] && interval_count_value_reg == 8'h00)
    else $error("wrap did not set overflow flag");
  a_step_increments: assert property (@(posedge core_clk) disable iff (reset)
    (step && !clear_req && !interval_count_clear_reg) |=>
      interval_count_value_reg == $past(interval_count_value_reg) + 8'h01)
    else $error("count did not advance");
  a_hold_no_step: assert property (@(posedge core_clk) disable iff (reset)
    (!step && !clear_req && !interval_count_clear_reg) |=> $stable(interval_count_value_reg))
    else $error("count moved without a pulse");
  a_read_gives_count: assert property (@(posedge core_clk) disable iff (reset)
    (reg_rd && sel_ctrl) |=> reg_rdata == $past(interval_count_value_reg))
    else $error("read data not the count");
  a_stop_no_tick: assert property (@(posedge core_clk) disable iff (reset)
    (pwr_reg == bitmr_pkg::BITMR_STOP) |-> tap_pulse == '0)
    else $error("prescaler ran while stopped");
  a_fastest_rate: assert property (@(posedge core_clk) disable iff (reset)
    (step && interval_clock_select_reg == 3'h0 && $stable(interval_clock_select_reg)
      && pwr_reg == bitmr_pkg::BITMR_RUN && !cpu_stop) |=> !step [*7])
    else $error("code 000 stepped faster than every 8 clocks");
  a_reset_values: assert property (@(posedge core_clk)
    (!reset && $past(reset)) |-> interval_count_value_reg == 8'h00 && irq_status_reg == 8'h00
      && irq_mask_reg == 8'h00 && !irq && !count_tick && reg_rdata == 8'h00)
    else $error("state not cleared by reset");
  // Step spacing per select code
  a_step_spacing: assert property (@(posedge core_clk) disable iff (reset)
    (step && gap_valid_reg) |-> step_gap_reg == (11'h008 << interval_clock_select_reg))
    else $error("step spacing does not match select code");
  a_tick_follows_step: assert property (@(posedge core_clk) disable iff (reset)
    1'b1 |=> count_tick == $past(step))
    else $error("tick does not follow count step");
  a_select_write: assert property (@(posedge core_clk) disable iff (reset)
    wr_ctrl |=> interval_clock_select_reg == $past(reg_wdata[bitmr_pkg::CSEL_W-1:0]))
    else $error("select not loaded by control write");
  a_select_hold: assert property (@(posedge core_clk) disable iff (reset)
    !wr_ctrl |=> $stable(interval_clock_select_reg))
    else $error("select changed without a write");
  // Self-clearing clear bit
  a_clear_sets_bit: assert property (@(posedge core_clk) disable iff (reset)
    clear_req |=> interval_count_clear_reg)
    else $error("clear bit not set by write");
  a_clear_only_req: assert property (@(posedge core_clk) disable iff (reset)
    !clear_req |=> !interval_count_clear_reg)
    else $error("clear bit set without a write");
  // Overflow flag and interrupt
  a_status_w1c: assert property (@(posedge core_clk) disable iff (reset)
    (wr_status && reg_wdata[bitmr_pkg::OVF_BIT] && !wrap) |=> !irq_status_reg[0])
    else $error("overflow flag not cleared by write one");
  a_status_set_wins: assert property (@(posedge core_clk) disable iff (reset)
    (wr_status && wrap) |=> irq_status_reg[0])
    else $error("clear beat a same-cycle overflow");
  a_status_sticky: assert property (@(posedge core_clk) disable iff (reset)
    (irq_status_reg[0] && !wr_status) |=> irq_status_reg[0])
    else $error("overflow flag dropped by itself");
  a_flag_only_wrap: assert property (@(posedge core_clk) disable iff (reset)
    (!wrap && !irq_status_reg[0]) |=> !irq_status_reg[0])
    else $error("overflow flag set without a wrap");
  a_irq_level_match: assert property (@(posedge core_clk) disable iff (reset)
    irq == |(irq_status_reg & $past(irq_mask_reg)))
    else $error("irq does not match masked status");
  a_irq_needs_mask: assert property (@(posedge core_clk) disable iff (reset)
    (irq_mask_reg == 8'h00 && !wr_mask) |=> !irq)
    else $error("irq raised while fully masked");
  a_mask_write: assert property (@(posedge core_clk) disable iff (reset)
    wr_mask |=> irq_mask_reg == $past(reg_wdata))
    else $error("mask not loaded by write");
  // Register port
  a_rdata_idle_zero: assert property (@(posedge core_clk) disable iff (reset)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_read_status: assert property (@(posedge core_clk) disable iff (reset)
    (reg_rd && sel_status) |=> reg_rdata == $past(irq_status_reg))
    else $error("read data not the status");
  a_read_mask: assert property (@(posedge core_clk) disable iff (reset)
    (reg_rd && sel_mask) |=> reg_rdata == $past(irq_mask_reg))
    else $error("read data not the mask");
  a_read_unmapped: assert property (@(posedge core_clk) disable iff (reset)
    (reg_rd && !sel_ctrl && !sel_status && !sel_mask) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_write_unmapped: assert property (@(posedge core_clk) disable iff (reset)
    (reg_wr && !sel_ctrl && !sel_status && !sel_mask) |=>
      $stable(irq_mask_reg) && $stable(interval_clock_select_reg))
    else $error("unmapped write changed a register");
  // Stop state
  a_stop_entry: assert property (@(posedge core_clk) disable iff (reset)
    cpu_stop |=> pwr_reg == bitmr_pkg::BITMR_STOP)
    else $error("stop state not entered");
  a_stop_exit: assert property (@(posedge core_clk) disable iff (reset)
    !cpu_stop |=> pwr_reg == bitmr_pkg::BITMR_RUN)
    else $error("stop state not left");
  a_no_step_stopped: assert property (@(posedge core_clk) disable iff (reset)
    (pwr_reg == bitmr_pkg::BITMR_STOP) |-> !step)
    else $error("counter stepped while stopped");
endmodule
`default_nettype wire

// ==== bench/bitmr_top_test.sv ====
// Purpose: Self-checking bench for the basic interval timer
// Assumes: 200 MHz core_clk, synchronous active-high reset
// Notes: Step spacing is measured between count_tick pulses
`timescale 1ns/1ps
`default_nettype none
module bitmr_top_test;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic cpu_stop = 1'b0;
  logic [7:0] reg_rdata;
  logic irq;
  logic count_tick;
  int n_fail = 0;
  int checked = 0;
  logic [7:0] d;
  logic [7:0] e;
  int n;

  // Bench clock stands in for main oscillation
  always #2.5 core_clk = ~core_clk;

  bitmr_top i_bitmr_top (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cpu_stop(cpu_stop), .irq(irq), .count_tick(count_tick));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      $display("mismatch %s expected %0h seen %0h", name, exp, got);
      n_fail++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Data stand only in the cycle after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic gap(output int k);
    k = 0;
    do begin
      @(posedge core_clk);
      #1 k++;
    end while (count_tick !== 1'b1 && k < 3000);
    if (k >= 3000) begin
      n_fail++;
      report_and_stop();
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rd(bitmr_pkg::ADDR_COUNT_CTRL, d);
    chk("count after reset", 16'h0000, {8'h00, d});
    rd(8'h10, d);
    chk("unmapped read", 16'h0000, {8'h00, d});
    wr(8'h10, 8'h00);
    gap(n);
    gap(n);
    chk("reset step gap", 16'd1024, 16'(n));
    $display("test reset done");
    for (int s = 0; s < 8; s++) begin
      wr(bitmr_pkg::ADDR_COUNT_CTRL, 8'(s));
      gap(n);
      gap(n);
      chk("select step gap", 16'(1 << (s + 3)), 16'(n));
    end
    $display("test select done");
    wr(bitmr_pkg::ADDR_COUNT_CTRL, 8'h08);
    rd(bitmr_pkg::ADDR_COUNT_CTRL, d);
    chk("count after clear", 16'h0000, {8'h00, d});
    cyc(20);
    rd(bitmr_pkg::ADDR_COUNT_CTRL, d);
    chk("resume after clear", 16'h0001, 16'(d >= 8'h01 && d <= 8'h03));
    $display("test clear done");
    wr(bitmr_pkg::ADDR_IRQ_MASK, 8'h01);
    wr(bitmr_pkg::ADDR_COUNT_CTRL, 8'h08);
    wr(bitmr_pkg::ADDR_IRQ_STATUS, 8'h01);
    cyc(2);
    chk("irq after w1c", 16'h0000, {15'h0000, irq});
    n = 0;
    while (irq !== 1'b1 && n < 2200) begin
      cyc(1);
      n++;
    end
    chk("overflow delay", 16'h0001, 16'(n >= 2020 && n <= 2070));
    rd(bitmr_pkg::ADDR_IRQ_STATUS, d);
    chk("status set", 16'h0001, {8'h00, d});
    wr(bitmr_pkg::ADDR_IRQ_MASK, 8'h00);
    cyc(2);
    chk("irq masked", 16'h0000, {15'h0000, irq});
    wr(bitmr_pkg::ADDR_IRQ_MASK, 8'h01);
    cyc(2);
    chk("irq unmasked", 16'h0001, {15'h0000, irq});
    wr(bitmr_pkg::ADDR_IRQ_STATUS, 8'h01);
    cyc(2);
    chk("irq cleared", 16'h0000, {15'h0000, irq});
    rd(bitmr_pkg::ADDR_IRQ_STATUS, d);
    chk("status cleared", 16'h0000, {8'h00, d});
    $display("test overflow done");
    wr(bitmr_pkg::ADDR_COUNT_CTRL, 8'h00);
    @(posedge core_clk);
    cpu_stop <= 1'b1;
    cyc(4);
    rd(bitmr_pkg::ADDR_COUNT_CTRL, d);
    n = 0;
    repeat (60) begin
      cyc(1);
      n += int'(count_tick === 1'b1);
    end
    rd(bitmr_pkg::ADDR_COUNT_CTRL, e);
    chk("frozen count", {8'h00, d}, {8'h00, e});
    chk("ticks in stop", 16'h0000, 16'(n));
    @(posedge core_clk);
    cpu_stop <= 1'b0;
    cyc(20);
    rd(bitmr_pkg::ADDR_COUNT_CTRL, d);
    chk("runs after stop", 16'h0001, 16'(d != e));
    $display("test stop done");
    report_and_stop();
  end
endmodule
`default_nettype wire
